// file: ionib_nib_model.sv
// Purpose: Model of the nibble logic that feeds status words and delay ready.
// Assumes: Status words change only when the bench loads them.
// Notes: Delay ready rises four cycles after a request and holds while requested.
`timescale 1ns/1ps
`default_nettype none
module ionib_nib_model (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic LOAD,
    input wire logic [47:0] NEW_WORDS,
    input wire logic DLY_REQ,
    output logic [15:0] CAL_WORD,
    output logic [15:0] EXT_WORD,
    output logic [15:0] WR_WORD,
    output logic DELAY_READY
);
    logic [1:0] wait_cnt;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {CAL_WORD, EXT_WORD, WR_WORD} <= 48'h0;
        end else if (LOAD) begin
            {CAL_WORD, EXT_WORD, WR_WORD} <= NEW_WORDS;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_cnt <= 2'h0;
            DELAY_READY <= 1'h0;
        end else if (!DLY_REQ) begin
            wait_cnt <= 2'h0;
            DELAY_READY <= 1'h0;
        end else if (wait_cnt != 2'h3) begin
            wait_cnt <= wait_cnt + 2'h1;
        end else begin
            DELAY_READY <= 1'h1;
        end
    end
endmodule : ionib_nib_model
`default_nettype wire

// file: ionib_pkg.sv
// Purpose: Constants for the nibble debug and control register bank.
// Assumes: AXI4-Lite slave with 32-bit data and 16-bit registers.
// Notes: The byte address of each register is four times its index.
package ionib_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int REG_W = 16;
    localparam int IDX_W = 8;
    localparam int ADDR_LSB = 2;
    localparam int SEL_W = 8;
    localparam int BYTE_W = 8;
    localparam logic [IDX_W-1:0] IDX_WR_STATUS = 8'h37;
    localparam logic [IDX_W-1:0] IDX_INDEX = 8'h38;
    localparam logic [IDX_W-1:0] IDX_RD_STATUS = 8'h39;
    localparam logic [IDX_W-1:0] IDX_CNT_CTRL = 8'h3A;
    localparam logic [IDX_W-1:0] IDX_UNDEC_LO = 8'h3B;
    localparam logic [IDX_W-1:0] IDX_UNDEC_HI = 8'h3F;
    localparam logic [IDX_W-1:0] IDX_NIB_A = 8'h40;
    localparam logic [IDX_W-1:0] IDX_NIB_B = 8'h41;
    localparam logic [REG_W-1:0] ZERO_REG = 16'h0000;
    localparam logic [REG_W-1:0] MASK_INDEX = 16'hFFFF;
    localparam logic [REG_W-1:0] MASK_CNT = 16'h0001;
    localparam logic [REG_W-1:0] MASK_NIB_A = 16'h007F;
    localparam logic [REG_W-1:0] MASK_NIB_B = 16'h0FFF;
    localparam logic [SEL_W-1:0] SEL_NONE = 8'h00;
    localparam int WSEL_LO = 8;
    localparam int RSEL_LO = 0;
    localparam int SEL_EXT_BIT = 7;
    localparam int CNT_GO_BIT = 0;
    localparam int NA_POS_SRC = 0;
    localparam int NA_NEG_SRC = 1;
    localparam int NA_RX_INV = 2;
    localparam int NA_SERIAL = 3;
    localparam int NA_TX_GATE_OFF = 4;
    localparam int NA_RX_GATE_OFF = 5;
    localparam int NA_RXGATE_EXT = 6;
    localparam int NB_RX_PH_P = 0;
    localparam int NB_RX_PH_N = 1;
    localparam int NB_TX_LO = 2;
    localparam int NB_TX_HI = 11;
    localparam int TX_PH_W = 10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    typedef enum logic [1:0] {
        IONIB_WR_IDLE = 2'b00,
        IONIB_WR_RESP = 2'b01
    } ionib_wr_e;
endpackage : ionib_pkg

// file: ionib_regs.sv
// Purpose: Debug status routing and nibble clock/phase control registers.
// Assumes: AXI4-Lite master; all inputs synchronous to CLK.
// Notes: Undecoded indices and reserved bits read zero and ignore writes.
// Summary of operation
// - Index upper byte routes write status; lower byte selects read status source.
// - Read status returns selected source word; read-only, resets to zero.
// - Debug control bit 0 starts the debug counter; other bits reserved.
// - Indices 0x3B to 0x3F are not decoded and hold no storage.
// - Control A bits 0 and 1 pick neighbour or own strobe clock.
// - Control A bit 2 inverts receive clock from the input buffer.
// - Control A bit 3 selects serial sampling; reverts when delay ready rises.
// - Control A bit 4 disables write clock gating.
// - Control A bit 5 disables read clock gating.
// - Control B bits 0 and 1 shift received clocks by 90 degrees.
// - Control B bits 2 to 11 delay each transmitter phase 90 degrees.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ionib_regs (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [ionib_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [ionib_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [ionib_pkg::STRB_W-1:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ionib_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [ionib_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [ionib_pkg::REG_W-1:0] WR_STATUS_IN,
    output logic [ionib_pkg::SEL_W-1:0] DEBUG_WRITE_SELECT,
    output logic CAL_WR_EN,
    output logic EXT_WR_EN,
    output logic [ionib_pkg::REG_W-1:0] WR_STATUS_OUT,
    output logic [ionib_pkg::SEL_W-1:0] DEBUG_READ_SELECT,
    input wire logic [ionib_pkg::REG_W-1:0] CAL_RD_STATUS,
    input wire logic [ionib_pkg::REG_W-1:0] EXT_RD_STATUS,
    output logic DEBUG_COUNTER_GO,
    output logic POS_STROBE_SOURCE_SEL,
    output logic NEG_STROBE_SOURCE_SEL,
    output logic RECEIVE_CLOCK_INVERT,
    output logic SERIAL_MODE,
    output logic TX_GATE_OFF,
    output logic RX_GATE_OFF,
    output logic RXGATE_EXTEND,
    input wire logic DELAY_READY,
    output logic RX_PHASE_P,
    output logic RX_PHASE_N,
    output logic [ionib_pkg::TX_PH_W-1:0] TX_PHASE_90
);
    import ionib_pkg::*;

    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[ADDR_W-1:ADDR_LSB];
    endfunction : reg_index

    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] d,
        input logic [STRB_W-1:0] s,
        input logic [REG_W-1:0] mask
    );
        logic [REG_W-1:0] m;
        m[BYTE_W-1:0] = s[0] ? d[BYTE_W-1:0] : old[BYTE_W-1:0];
        m[REG_W-1:BYTE_W] = s[1] ? d[REG_W-1:BYTE_W] : old[REG_W-1:BYTE_W];
        merge = m & mask;
    endfunction : merge

    function automatic logic is_undec(input logic [IDX_W-1:0] i);
        is_undec = (i >= IDX_UNDEC_LO) && (i <= IDX_UNDEC_HI);
    endfunction : is_undec

    ionib_wr_e wr_state;
    ionib_wr_e next_wr_state;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic wr_go;
    logic [IDX_W-1:0] wr_idx;
    logic [REG_W-1:0] sel_index;
    logic [REG_W-1:0] cnt_ctrl;
    logic [REG_W-1:0] nib_a;
    logic [REG_W-1:0] nib_b;
    logic [REG_W-1:0] wr_status;
    logic [REG_W-1:0] rd_status;
    logic dly_q;
    logic dly_rise;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [REG_W-1:0] next_rd_value;
    logic [SEL_W-1:0] wsel;
    logic [SEL_W-1:0] rsel;

    // Write channel: address and data are taken independently, then applied.
    assign S_AXI_AWREADY = (wr_state == IONIB_WR_IDLE) && !aw_held;
    assign S_AXI_WREADY = (wr_state == IONIB_WR_IDLE) && !w_held;
    assign S_AXI_BVALID = (wr_state == IONIB_WR_RESP);
    assign S_AXI_BRESP = RESP_OKAY;
    assign wr_go = (wr_state == IONIB_WR_IDLE) && aw_held && w_held;
    assign wr_idx = reg_index(aw_addr);

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            IONIB_WR_IDLE: begin
                if (wr_go) begin
                    next_wr_state = IONIB_WR_RESP;
                end
            end
            IONIB_WR_RESP: begin
                if (S_AXI_BREADY) begin
                    next_wr_state = IONIB_WR_IDLE;
                end
            end
            default: begin
                next_wr_state = IONIB_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_state <= IONIB_WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // Writable registers; any other index, including 0x3B-0x3F, is dropped.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_index <= ZERO_REG;
        end else if (wr_go && wr_idx == IDX_INDEX) begin
            sel_index <= merge(sel_index, w_data, w_strb, MASK_INDEX);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_ctrl <= ZERO_REG;
        end else if (wr_go && wr_idx == IDX_CNT_CTRL) begin
            cnt_ctrl <= merge(cnt_ctrl, w_data, w_strb, MASK_CNT);
        end
    end

    // A rising delay ready returns serial mode to its reset value; software
    // must write it again afterwards. The revert wins over a same-cycle write.
    assign dly_rise = DELAY_READY && !dly_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dly_q <= 1'b0;
        end else begin
            dly_q <= DELAY_READY;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            nib_a <= ZERO_REG;
        end else begin
            if (wr_go && wr_idx == IDX_NIB_A) begin
                nib_a <= merge(nib_a, w_data, w_strb, MASK_NIB_A);
            end
            if (dly_rise) begin
                nib_a[NA_SERIAL] <= ZERO_REG[NA_SERIAL];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            nib_b <= ZERO_REG;
        end else if (wr_go && wr_idx == IDX_NIB_B) begin
            nib_b <= merge(nib_b, w_data, w_strb, MASK_NIB_B);
        end
    end

    // Debug status routing and capture.
    assign wsel = sel_index[WSEL_LO+SEL_W-1:WSEL_LO];
    assign rsel = sel_index[RSEL_LO+SEL_W-1:RSEL_LO];
    assign DEBUG_WRITE_SELECT = wsel;
    assign DEBUG_READ_SELECT = rsel;
    assign CAL_WR_EN = (wsel != SEL_NONE) && !wsel[SEL_EXT_BIT];
    assign EXT_WR_EN = wsel[SEL_EXT_BIT];
    assign WR_STATUS_OUT = wr_status;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_status <= ZERO_REG;
        end else begin
            wr_status <= WR_STATUS_IN;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_status <= ZERO_REG;
        end else begin
            rd_status <= rsel[SEL_EXT_BIT] ? EXT_RD_STATUS : CAL_RD_STATUS;
        end
    end

    assign DEBUG_COUNTER_GO = cnt_ctrl[CNT_GO_BIT];
    assign POS_STROBE_SOURCE_SEL = nib_a[NA_POS_SRC];
    assign NEG_STROBE_SOURCE_SEL = nib_a[NA_NEG_SRC];
    assign RECEIVE_CLOCK_INVERT = nib_a[NA_RX_INV];
    assign SERIAL_MODE = nib_a[NA_SERIAL];
    assign TX_GATE_OFF = nib_a[NA_TX_GATE_OFF];
    assign RX_GATE_OFF = nib_a[NA_RX_GATE_OFF];
    assign RXGATE_EXTEND = nib_a[NA_RXGATE_EXT];
    assign RX_PHASE_P = nib_b[NB_RX_PH_P];
    assign RX_PHASE_N = nib_b[NB_RX_PH_N];
    assign TX_PHASE_90 = nib_b[NB_TX_HI:NB_TX_LO];

    // Read channel: one read at a time, answered from a flop the next cycle.
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = RESP_OKAY;

    always_comb begin
        case (reg_index(S_AXI_ARADDR))
            IDX_WR_STATUS: next_rd_value = wr_status;
            IDX_INDEX: next_rd_value = sel_index;
            IDX_RD_STATUS: next_rd_value = rd_status;
            IDX_CNT_CTRL: next_rd_value = cnt_ctrl;
            IDX_NIB_A: next_rd_value = nib_a;
            IDX_NIB_B: next_rd_value = nib_b;
            default: next_rd_value = ZERO_REG;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rvalid <= 1'b0;
            rdata <= '0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid <= 1'b1;
            rdata <= {{(DATA_W-REG_W){1'b0}}, next_rd_value};
        end else if (S_AXI_RREADY) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence index_write_s;
        wr_go && wr_idx == IDX_INDEX && w_strb == 4'hF;
    endsequence

    sequence ar_take_s(logic [IDX_W-1:0] lo, logic [IDX_W-1:0] hi);
        S_AXI_ARVALID && S_AXI_ARREADY
            && reg_index(S_AXI_ARADDR) >= lo && reg_index(S_AXI_ARADDR) <= hi;
    endsequence

    index_route_a: assert property (index_write_s |=>
        DEBUG_WRITE_SELECT == $past(w_data[REG_W-1:WSEL_LO])
        && EXT_WR_EN == $past(w_data[REG_W-1])
        && CAL_WR_EN == ($past(w_data[REG_W-1:WSEL_LO]) inside {[8'h01:8'h7F]}))
        else $error("write status route does not follow index");

    rd_status_mux_a: assert property (1'b1 |=>
        rd_status == ($past(rsel[SEL_EXT_BIT]) ? $past(EXT_RD_STATUS) : $past(CAL_RD_STATUS)))
        else $error("read status not taken from selected source");

    cnt_go_write_a: assert property (wr_go && wr_idx == IDX_CNT_CTRL && w_strb[0] |=>
        DEBUG_COUNTER_GO == $past(w_data[CNT_GO_BIT]) && cnt_ctrl[REG_W-1:1] == '0)
        else $error("counter start bit not written");

    undec_read_a: assert property (ar_take_s(IDX_UNDEC_LO, IDX_UNDEC_HI) |=>
        S_AXI_RVALID && S_AXI_RDATA == '0)
        else $error("undecoded index read non-zero");

    undec_write_a: assert property (wr_go && is_undec(wr_idx) |=>
        $stable(sel_index) && $stable(cnt_ctrl) && $stable(nib_b))
        else $error("undecoded write changed storage");

    reserved_zero_a: assert property (S_AXI_RVALID |->
        S_AXI_RDATA[DATA_W-1:REG_W] == '0)
        else $error("reserved read bits not zero");

    nib_a_write_a: assert property (wr_go && wr_idx == IDX_NIB_A && w_strb[0] |=>
        {RX_GATE_OFF, TX_GATE_OFF, RECEIVE_CLOCK_INVERT, NEG_STROBE_SOURCE_SEL,
        POS_STROBE_SOURCE_SEL} == {$past(w_data[5:4]), $past(w_data[2:0])})
        else $error("control A bits not applied");

    serial_revert_a: assert property (dly_rise |=> !SERIAL_MODE)
        else $error("serial mode did not revert on delay ready");

    nib_b_write_a: assert property (wr_go && wr_idx == IDX_NIB_B && w_strb[1:0] == 2'h3 |=>
        {TX_PHASE_90, RX_PHASE_N, RX_PHASE_P} == $past(w_data[NB_TX_HI:0]))
        else $error("control B bits not applied");

    resp_after_go_a: assert property (wr_go |=> S_AXI_BVALID [*1] ##0 !S_AXI_AWREADY)
        else $error("write response missing");

    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped before ready");

endmodule : ionib_regs
`default_nettype wire

// file: ionib_regs_tb.sv
// Purpose: Self-checking bench for the nibble debug and control register bank.
// Assumes: AXI4-Lite master tasks sample handshakes before each rising edge.
// Notes: Random data come from an xorshift generator with a fixed start value.
`timescale 1ns/1ps
`default_nettype none
module ionib_regs_tb;
    import ionib_pkg::*;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [STRB_W-1:0] wstrb = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic load = 1'h0, dly_req = 1'h0;
    logic [47:0] words = '0;
    logic [31:0] rng = 32'h0000B601;
    logic [31:0] v;
    logic [15:0] ix;
    logic [15:0] corners [5] = '{16'h0000, 16'h0001, 16'h7F7F, 16'h8080, 16'hFFFF};
    wire awready, wready, bvalid, arready, rvalid, cal_en, ext_en, cnt_go, delay_ready;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] wsel, rsel;
    wire [15:0] wr_out, cal_w, ext_w, wr_w;
    wire [6:0] na;
    wire [11:0] nb;
    int err_count = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    ionib_regs i_ionib_regs (.CLK(clk), .RESET_N(reset_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .WR_STATUS_IN(wr_w), .DEBUG_WRITE_SELECT(wsel), .CAL_WR_EN(cal_en), .EXT_WR_EN(ext_en),
        .WR_STATUS_OUT(wr_out), .DEBUG_READ_SELECT(rsel), .CAL_RD_STATUS(cal_w),
        .EXT_RD_STATUS(ext_w), .DEBUG_COUNTER_GO(cnt_go), .POS_STROBE_SOURCE_SEL(na[0]),
        .NEG_STROBE_SOURCE_SEL(na[1]), .RECEIVE_CLOCK_INVERT(na[2]), .SERIAL_MODE(na[3]),
        .TX_GATE_OFF(na[4]), .RX_GATE_OFF(na[5]), .RXGATE_EXTEND(na[6]),
        .DELAY_READY(delay_ready), .RX_PHASE_P(nb[0]), .RX_PHASE_N(nb[1]), .TX_PHASE_90(nb[11:2]));

    ionib_nib_model i_ionib_nib_model (.CLK(clk), .RESET_N(reset_n), .LOAD(load),
        .NEW_WORDS(words), .DLY_REQ(dly_req), .CAL_WORD(cal_w), .EXT_WORD(ext_w),
        .WR_WORD(wr_w), .DELAY_READY(delay_ready));

    function automatic logic [31:0] rand32();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rand32

    function automatic logic [31:0] exp_stat(input logic [15:0] sel);
        return {16'h0, sel[7] ? words[31:16] : words[47:32]};
    endfunction : exp_stat

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Each channel is released at the edge where its own handshake completes.
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hF);
        bit ha, hw, db;
        logic [1:0] br;
        db = 1'b0;
        br = 2'h3;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int n = 0; n < 50 && !db; n++) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            db = bready && bvalid;
            br = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
            if (db) bready <= 1'h0;
        end
        if (!db) begin
            err_count++;
            test_done();
        end
        chk("bresp", 32'h0, {30'h0, br});
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        bit ha, dr;
        logic [31:0] d;
        logic [1:0] rr;
        dr = 1'b0;
        rr = 2'h3;
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int n = 0; n < 50 && !dr; n++) begin
            @(negedge clk);
            ha = arvalid && arready;
            dr = rready && rvalid;
            d = rdata;
            rr = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'h0;
            if (dr) rready <= 1'h0;
        end
        if (!dr) begin
            err_count++;
            test_done();
        end
        chk(name, exp, d);
        chk("rresp", 32'h0, {30'h0, rr});
    endtask : rchk

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        for (int i = 8'h37; i <= 8'h41; i++) rchk("reset", 8'(i), 32'h0);
        words <= {rand32(), 16'(rand32())};
        load <= 1'h1;
        @(posedge clk);
        load <= 1'h0;
        for (int i = 0; i < 9; i++) begin
            ix = (i < 5) ? corners[i] : 16'(rand32());
            v = rand32();
            wr(IDX_INDEX, {v[31:16], ix});
            chk("wr_sel", {24'h0, ix[15:8]}, {24'h0, wsel});
            chk("wr_route", {30'h0, ix[15], ix[15:8] != 8'h00 && !ix[15]}, {30'h0, ext_en, cal_en});
            chk("rd_sel", {24'h0, ix[7:0]}, {24'h0, rsel});
            rchk("index", IDX_INDEX, {16'h0, ix});
            rchk("rd_status", IDX_RD_STATUS, exp_stat(ix));
        end
        chk("wr_out", {16'h0, words[15:0]}, {16'h0, wr_out});
        rchk("wr_status", IDX_WR_STATUS, {16'h0, words[15:0]});
        wr(IDX_CNT_CTRL, 32'hFFFFFFFF);
        chk("go", 32'h1, {31'h0, cnt_go});
        rchk("cnt", IDX_CNT_CTRL, 32'h1);
        for (int i = 8'h3B; i <= 8'h3F; i++) begin
            wr(8'(i), 32'hFFFFFFFF);
            rchk("undec", 8'(i), 32'h0);
        end
        rchk("index_kept", IDX_INDEX, {16'h0, ix});
        wr(IDX_INDEX, 32'h0000A5C3, 4'h2);
        rchk("index_lane", IDX_INDEX, {16'h0, 8'hA5, ix[7:0]});
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hFFFFFFFF : rand32();
            wr(IDX_NIB_A, v);
            chk("ctrl_a", {25'h0, v[6:0]}, {25'h0, na});
            rchk("ctrl_a_rd", IDX_NIB_A, {16'h0, v[15:0] & MASK_NIB_A});
            v = (i == 0) ? 32'hFFFFFFFF : rand32();
            wr(IDX_NIB_B, v);
            chk("ctrl_b", {20'h0, v[11:0]}, {20'h0, nb});
            rchk("ctrl_b_rd", IDX_NIB_B, {16'h0, v[15:0] & MASK_NIB_B});
        end
        wr(IDX_NIB_A, 32'h8);
        dly_req <= 1'h1;
        for (int n = 0; n < 20 && delay_ready !== 1'h1; n++) @(negedge clk);
        if (delay_ready !== 1'h1) begin
            err_count++;
            test_done();
        end
        repeat (3) @(posedge clk);
        chk("serial_revert", 32'h0, {31'h0, na[3]});
        wr(IDX_NIB_A, 32'h8);
        chk("serial_rewrite", 32'h1, {31'h0, na[3]});
        dly_req <= 1'h0;
        test_done();
    end
endmodule : ionib_regs_tb
`default_nettype wire
